// ---- src/rtc_ctrl_pkg.sv ----
package rtc_ctrl_pkg;
  // ==========================================================
  // register map (byte addresses, one word each)
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] TIME_OFFSET = 12'h004;
  localparam logic [11:0] KEY_OFFSET = 12'h008;
  localparam int ADDR_W = 12;
  // ==========================================================
  // control register fields
  localparam int TRIM_MSB = 25;
  localparam int TRIM_LSB = 16;
  localparam int TRIM_W = 10;
  localparam int ON_BIT = 15;
  localparam int IDLE_STOP_BIT = 13;
  localparam int SRC_SEL_BIT = 7;
  localparam int RUNNING_BIT = 6;
  localparam int UNLOCK_BIT = 3;
  localparam int SYNC_BIT = 2;
  localparam int HALF_SEC_BIT = 1;
  localparam int PIN_OE_BIT = 0;
  // ==========================================================
  // time register fields
  localparam int SEC_MSB = 14;
  localparam int SEC_LSB = 8;
  localparam int SEC_W = 7;
  localparam logic [6:0] SEC_LAST = 7'h3B;
  // ==========================================================
  // write sequence keys, written one after the other
  localparam logic [31:0] KEY_FIRST = 32'h0000_00AA;
  localparam logic [31:0] KEY_SECOND = 32'h0000_0055;
  // ==========================================================
  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [6:0] SEC_RESET = 7'h00;
  localparam int TICKS_PER_SEC = 32768;
endpackage

// ---- src/rtc_ctrl.sv ----
`timescale 1ns/10ps
// How it works
// - trim field sits at bits 25..16 and is a signed ten-bit number
// - positive trim inserts that many extra pulses each minute, up to 511
// - negative trim removes pulses each minute; all ones one, minimum 512
// - enable bit 15 runs the clock; clearing it stops the clock
// - enable bit changes only while the write-unlock bit is set
// - write-unlock can be set only after the key write sequence
// - stop-in-idle bit 13 gates the bus clock while the processor idles
// - select bit 7 routes seconds clock when 1, alarm pulse when 0
// - clock pin shows the selected signal only when bit 0 is set
// - status bit 6 reads 1 while the clock runs, else 0
// - half-second flag is read-only; seconds writes force it to zero
// - control register is cleared only by power-on reset
module rtc_ctrl #(
  parameter int TICKS_PER_SEC = rtc_ctrl_pkg::TICKS_PER_SEC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rtc_ctrl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rtc_tick_in,
  input wire logic alarm_pulse,
  input wire logic cpu_idle,
  output logic bus_clk_gate_en,
  output logic clock_pin_out,
  output logic clock_pin_oe
);
  import rtc_ctrl_pkg::*;

  localparam int PRE_W = $clog2(TICKS_PER_SEC);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICKS_PER_SEC - 1);
  localparam logic [PRE_W-1:0] PRE_HALF = PRE_W'(TICKS_PER_SEC / 2);

  function automatic logic [TRIM_W-1:0] trim_mag(
    input logic [TRIM_W-1:0] t
  );
    trim_mag = t[TRIM_W-1] ? TRIM_W'(~t + 1'b1) : t;
  endfunction

  // ==========================================================
  // bus decode
  logic setup_ph, wr_acc, rd_setup, hit_ctrl, hit_time, hit_key, mapped;
  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = setup_ph & ~pwrite;
  assign hit_ctrl = (paddr == CTRL_OFFSET);
  assign hit_time = (paddr == TIME_OFFSET);
  assign hit_key = (paddr == KEY_OFFSET);
  assign mapped = hit_ctrl | hit_time | hit_key;
  // zero wait states, so read data is loaded in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ==========================================================
  // tick pin synchroniser
  logic tick_s1_r, tick_s2_r, tick_s3_r, tick;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_s1_r <= 1'b0;
      tick_s2_r <= 1'b0;
      tick_s3_r <= 1'b0;
    end else begin
      tick_s1_r <= rtc_tick_in;
      tick_s2_r <= tick_s1_r;
      tick_s3_r <= tick_s2_r;
    end
  end
  // the first flop never feeds logic; the third is the edge memory
  assign tick = tick_s2_r & ~tick_s3_r;

  // ==========================================================
  // control register and write sequence
  logic [TRIM_W-1:0] trim_r, trim_nxt;
  logic on_r, on_nxt, idle_stop_r, idle_stop_nxt;
  logic src_sel_r, src_sel_nxt, pin_oe_r, pin_oe_nxt;
  logic unlock_r, unlock_nxt, key_half_r, key_half_nxt;
  logic seq_armed_r, seq_armed_nxt;
  logic ctrl_wr, time_wr, key_wr;
  assign ctrl_wr = wr_acc & hit_ctrl;
  assign time_wr = wr_acc & hit_time;
  assign key_wr = wr_acc & hit_key;

  always_comb begin
    trim_nxt = trim_r;
    on_nxt = on_r;
    idle_stop_nxt = idle_stop_r;
    src_sel_nxt = src_sel_r;
    pin_oe_nxt = pin_oe_r;
    unlock_nxt = unlock_r;
    key_half_nxt = key_half_r;
    seq_armed_nxt = seq_armed_r;
    if (key_wr) begin
      // any wrong word restarts the sequence
      key_half_nxt = (pwdata == KEY_FIRST);
      seq_armed_nxt = key_half_r & (pwdata == KEY_SECOND);
    end
    if (ctrl_wr) begin
      trim_nxt = pwdata[TRIM_MSB:TRIM_LSB];
      idle_stop_nxt = pwdata[IDLE_STOP_BIT];
      src_sel_nxt = pwdata[SRC_SEL_BIT];
      pin_oe_nxt = pwdata[PIN_OE_BIT];
      // the unlock state before this write decides the enable
      if (unlock_r) begin
        on_nxt = pwdata[ON_BIT];
      end
      if (!pwdata[UNLOCK_BIT]) begin
        unlock_nxt = 1'b0;
      end else if (seq_armed_r) begin
        unlock_nxt = 1'b1;
        seq_armed_nxt = 1'b0;
      end
    end
  end

  // presetn is the power-on reset; no other reset reaches here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_r <= CTRL_RESET[TRIM_MSB:TRIM_LSB];
      on_r <= CTRL_RESET[ON_BIT];
      idle_stop_r <= CTRL_RESET[IDLE_STOP_BIT];
      src_sel_r <= CTRL_RESET[SRC_SEL_BIT];
      pin_oe_r <= CTRL_RESET[PIN_OE_BIT];
      unlock_r <= CTRL_RESET[UNLOCK_BIT];
      key_half_r <= 1'b0;
      seq_armed_r <= 1'b0;
    end else begin
      trim_r <= trim_nxt;
      on_r <= on_nxt;
      idle_stop_r <= idle_stop_nxt;
      src_sel_r <= src_sel_nxt;
      pin_oe_r <= pin_oe_nxt;
      unlock_r <= unlock_nxt;
      key_half_r <= key_half_nxt;
      seq_armed_r <= seq_armed_nxt;
    end
  end

  // ==========================================================
  // prescaler, seconds and drift trim
  logic [PRE_W-1:0] pre_r, pre_nxt;
  logic [SEC_W-1:0] sec_r, sec_nxt;
  logic [TRIM_W-1:0] adj_cnt_r, adj_cnt_nxt;
  logic adj_neg_r, adj_neg_nxt;
  logic step, insert, remove, sec_wrap, minute_evt;

  // inserted pulses use idle cycles, so one step per cycle at most
  assign insert = on_r & ~adj_neg_r & (adj_cnt_r != '0) & ~tick;
  assign remove = on_r & adj_neg_r & (adj_cnt_r != '0) & tick;
  assign step = on_r & ((tick & ~remove) | insert);
  assign sec_wrap = step & (pre_r == PRE_LAST);
  assign minute_evt = sec_wrap & (sec_r == SEC_LAST);

  always_comb begin
    pre_nxt = pre_r;
    sec_nxt = sec_r;
    adj_cnt_nxt = adj_cnt_r;
    adj_neg_nxt = adj_neg_r;
    if (insert | remove) begin
      adj_cnt_nxt = adj_cnt_r - 1'b1;
    end
    if (step) begin
      pre_nxt = sec_wrap ? '0 : pre_r + 1'b1;
    end
    if (sec_wrap) begin
      sec_nxt = (sec_r == SEC_LAST) ? '0 : sec_r + 1'b1;
    end
    if (minute_evt) begin
      adj_cnt_nxt = trim_mag(trim_r);
      adj_neg_nxt = trim_r[TRIM_W-1];
    end
    if (time_wr) begin
      sec_nxt = pwdata[SEC_MSB:SEC_LSB];
      pre_nxt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= '0;
      sec_r <= SEC_RESET;
      adj_cnt_r <= '0;
      adj_neg_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      sec_r <= sec_nxt;
      adj_cnt_r <= adj_cnt_nxt;
      adj_neg_r <= adj_neg_nxt;
    end
  end

  logic half_flag, sync_flag, running;
  assign half_flag = (pre_r >= PRE_HALF);
  assign sync_flag = (adj_cnt_r != '0);
  assign running = on_r;

  // ==========================================================
  // pin output, bus clock gate, read data
  logic pin_r, pin_nxt, gate_r, gate_nxt;
  logic [31:0] prdata_r, prdata_nxt;

  always_comb begin
    pin_nxt = 1'b0;
    if (pin_oe_r) begin
      pin_nxt = src_sel_r ? ~half_flag : alarm_pulse;
    end
    gate_nxt = ~(idle_stop_r & cpu_idle);
    prdata_nxt = prdata_r;
    if (rd_setup) begin
      prdata_nxt = '0;
      if (hit_ctrl) begin
        prdata_nxt[TRIM_MSB:TRIM_LSB] = trim_r;
        prdata_nxt[ON_BIT] = on_r;
        prdata_nxt[IDLE_STOP_BIT] = idle_stop_r;
        prdata_nxt[SRC_SEL_BIT] = src_sel_r;
        prdata_nxt[RUNNING_BIT] = running;
        prdata_nxt[UNLOCK_BIT] = unlock_r;
        prdata_nxt[SYNC_BIT] = sync_flag;
        prdata_nxt[HALF_SEC_BIT] = half_flag;
        prdata_nxt[PIN_OE_BIT] = pin_oe_r;
      end else if (hit_time) begin
        prdata_nxt[SEC_MSB:SEC_LSB] = sec_r;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_r <= 1'b0;
      gate_r <= 1'b1;
      prdata_r <= '0;
    end else begin
      pin_r <= pin_nxt;
      gate_r <= gate_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;
  assign clock_pin_out = pin_r;
  assign clock_pin_oe = pin_oe_r;
  assign bus_clk_gate_en = gate_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_minute_wrap;
    minute_evt ##1 1'b1;
  endsequence

  sequence seq_locked_write;
    ctrl_wr && !unlock_r;
  endsequence

  chk_trim_load: assert property (
    minute_evt && !time_wr |=> adj_cnt_r == trim_mag($past(trim_r))
      && adj_neg_r == $past(trim_r[TRIM_W-1]))
    else $error("trim not loaded at minute wrap");

  chk_pos_insert: assert property (
    seq_minute_wrap ##0 (on_r && !adj_neg_r && adj_cnt_r != '0 && !tick
      && !time_wr && pre_r != PRE_LAST) |=> pre_r == $past(pre_r) + 1'b1)
    else $error("extra pulse not inserted");

  chk_neg_skip: assert property (
    on_r && adj_neg_r && adj_cnt_r != '0 && tick && !time_wr
      |=> pre_r == $past(pre_r) && adj_cnt_r == $past(adj_cnt_r) - 1'b1)
    else $error("pulse not removed");

  chk_off_hold: assert property (
    !on_r && !time_wr |=> $stable(pre_r) && $stable(sec_r))
    else $error("clock advanced while disabled");

  chk_enable_locked: assert property (
    seq_locked_write |=> on_r == $past(on_r))
    else $error("enable changed while locked");

  chk_unlock_armed: assert property (
    $rose(unlock_r) |-> $past(seq_armed_r) && $past(ctrl_wr))
    else $error("unlock set without write sequence");

  chk_idle_gate: assert property (
    idle_stop_r && cpu_idle ##1 $stable(idle_stop_r) |-> !bus_clk_gate_en)
    else $error("bus clock not gated in idle");

  chk_pin_route: assert property (
    ##1 clock_pin_out == ($past(pin_oe_r) && ($past(src_sel_r)
      ? !$past(half_flag) : $past(alarm_pulse))))
    else $error("clock pin shows wrong source");

  chk_running_read: assert property (
    rd_setup && hit_ctrl |=> prdata[RUNNING_BIT] == $past(on_r))
    else $error("running status wrong");

  chk_half_clear: assert property (
    time_wr |=> !half_flag && pre_r == '0)
    else $error("half-second flag not cleared");

  sequence seq_unlock_write;
    ctrl_wr && unlock_r;
  endsequence

  chk_enable_write: assert property (
    seq_unlock_write |=> on_r == $past(pwdata[ON_BIT]))
    else $error("enable write lost while unlocked");

  chk_unlock_clear: assert property (
    ctrl_wr && !pwdata[UNLOCK_BIT] |=> !unlock_r)
    else $error("write-unlock not cleared");

  chk_trim_store: assert property (
    ctrl_wr |=> trim_r == $past(pwdata[TRIM_MSB:TRIM_LSB]))
    else $error("trim field not stored");

  chk_tick_step: assert property (
    on_r && tick && !adj_neg_r && !time_wr && pre_r != PRE_LAST
      |=> pre_r == $past(pre_r) + 1'b1)
    else $error("tick did not advance the prescaler");

  chk_insert_count: assert property (
    insert && !minute_evt |=> adj_cnt_r == $past(adj_cnt_r) - 1'b1)
    else $error("inserted pulse not counted");

  chk_idle_store: assert property (
    ctrl_wr |=> idle_stop_r == $past(pwdata[IDLE_STOP_BIT]))
    else $error("stop-in-idle bit not stored");

  chk_gate_open: assert property (
    !(idle_stop_r && cpu_idle) |=> bus_clk_gate_en)
    else $error("bus clock gated outside idle stop");

  chk_sel_store: assert property (
    ctrl_wr |=> src_sel_r == $past(pwdata[SRC_SEL_BIT]))
    else $error("output select bit not stored");

  chk_pin_oe_bit: assert property (
    ctrl_wr |=> clock_pin_oe == $past(pwdata[PIN_OE_BIT]))
    else $error("pin output enable not stored");

endmodule // rtc_ctrl

// ---- tb/test_rtc_control_register.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module test_rtc_control_register;
  import rtc_ctrl_pkg::*;
  // ==========================================================
  // bench signals, short second so a minute wrap stays cheap
  localparam int TPS = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, bus_clk_gate_en, clock_pin_out, clock_pin_oe;
  logic rtc_tick_in = 1'b0;
  logic alarm_pulse = 1'b0;
  logic cpu_idle = 1'b0;
  int n_fail = 0;
  int checks = 0;
  int ctrl_m = 0;
  int armed = 0;
  int trims [4] = '{5, -1, 0, -3};
  integer seed = 32'hf613f9a9;
  logic [31:0] rnd;

  always #2 pclk = ~pclk;

  rtc_ctrl #(.TICKS_PER_SEC(TPS)) i_rtc_ctrl (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rtc_tick_in(rtc_tick_in),
    .alarm_pulse(alarm_pulse), .cpu_idle(cpu_idle),
    .bus_clk_gate_en(bus_clk_gate_en), .clock_pin_out(clock_pin_out),
    .clock_pin_oe(clock_pin_oe));

  // ==========================================================
  // tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      stop_test();
    end
  endtask

  // enable only moves while unlock was already set; unlock needs the keys
  task automatic wr_ctrl(input logic [31:0] d);
    int nx;
    nx = d & 32'h03FF_2081;
    nx |= (ctrl_m[3] ? int'(d) : ctrl_m) & 32'h8000;
    if (d[3] && (ctrl_m[3] || armed != 0)) nx |= 8;
    if (d[3] && !ctrl_m[3]) armed = 0;
    apb(1'b1, CTRL_OFFSET, d);
    ctrl_m = nx;
  endtask

  function automatic logic [31:0] exp_ctrl();
    return ctrl_m | (ctrl_m[15] ? 32'h40 : 32'h0);
  endfunction

  task automatic rd_ctrl();
    apb(1'b0, CTRL_OFFSET, 32'h0);
    rd = rd & 32'hFFFF_FFF9;
  endtask

  task automatic arm();
    apb(1'b1, KEY_OFFSET, KEY_FIRST);
    apb(1'b1, KEY_OFFSET, KEY_SECOND);
    armed = 1;
  endtask

  task automatic tick(input int k);
    repeat (k) begin
      rtc_tick_in <= 1'b1;
      repeat (3) @(posedge pclk);
      rtc_tick_in <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd_ctrl();
    `CHK(rd, CTRL_RESET)
    `CHK({clock_pin_oe, clock_pin_out}, 2'b00)
    apb(1'b0, 12'h00C, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    $display("test reset done");
    rnd = $random(seed);
    wr_ctrl(rnd | 32'h0000_8008);
    rd_ctrl();
    `CHK(rd, exp_ctrl())
    arm();
    wr_ctrl(32'h0000_0008);
    wr_ctrl(32'h0000_8008);
    rd_ctrl();
    `CHK(rd, exp_ctrl())
    wr_ctrl(32'h0000_0008); // next access waits an idle cycle
    rd_ctrl();
    `CHK(rd, exp_ctrl())
    wr_ctrl(32'h0000_8008);
    wr_ctrl(32'h0000_8000);
    wr_ctrl(32'h0000_0000);
    rd_ctrl();
    `CHK(rd, exp_ctrl())
    arm();
    wr_ctrl(32'h0000_8008);
    $display("test lock done");
    for (int i = 0; i < 16; i++) begin
      rnd = $random(seed);
      wr_ctrl(32'h8008 | (i[0] << 7) | i[1] | (i[2] << 13));
      alarm_pulse <= rnd[0];
      cpu_idle <= i[3];
      repeat (3) @(posedge pclk);
      `CHK(clock_pin_oe, i[1])
      `CHK(clock_pin_out, i[1] & (i[0] | rnd[0]))
      `CHK(bus_clk_gate_en, !(i[2] && i[3]))
    end
    cpu_idle <= 1'b0;
    $display("test pin done");
    wr_ctrl(32'h0000_8089);
    apb(1'b1, TIME_OFFSET, 32'h0);
    tick(TPS / 2);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    `CHK({rd[1], clock_pin_out}, 2'b10)
    apb(1'b1, TIME_OFFSET, 32'h0000_0500);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    `CHK({rd[1], clock_pin_out}, 2'b01)
    $display("test half done");
    foreach (trims[k]) begin
      wr_ctrl(32'h8009 | ((trims[k] & 32'h3FF) << 16));
      rd_ctrl();
      `CHK(rd, exp_ctrl())
      apb(1'b1, TIME_OFFSET, 32'h0000_3B00);
      tick(TPS);
      apb(1'b0, TIME_OFFSET, 32'h0);
      `CHK(rd & 32'h7F00, 32'h0)
      apb(1'b0, CTRL_OFFSET, 32'h0);
      `CHK(rd[2], trims[k] < 0)
      tick(TPS - trims[k] - 1);
      apb(1'b0, TIME_OFFSET, 32'h0);
      `CHK(rd & 32'h7F00, 32'h0)
      tick(1);
      apb(1'b0, TIME_OFFSET, 32'h0);
      `CHK(rd & 32'h7F00, 32'h100)
    end
    $display("test trim done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    ctrl_m = 0;
    armed = 0;
    rd_ctrl();
    `CHK(rd, CTRL_RESET)
    $display("test second reset done");
    stop_test();
  end
endmodule // test_rtc_control_register
